// >>> host_model.sv
// Host processor model for the register port
`timescale 1ns/10ps
module host_model (
    // Clock and answers
    input wire logic MCLK,
    input wire logic SLAVE_SYNC,
    input wire logic [15:0] REG_RDATA,
    // Requests
    output logic REG_WR,
    output logic REG_RD,
    output logic [15:0] REG_WDATA
);
    // Idle bus at time zero
    initial begin
        REG_WR = 1'h0;
        REG_RD = 1'h0;
        REG_WDATA = 16'hFFFF;
    end

    // Entered at a falling edge; request held until acknowledge is seen before a rising edge, for at most 8 falling edges
    task automatic xfer(input logic wr, input logic [15:0] d, output logic [15:0] q,
                        output int n);
        logic ack;
        REG_WR = wr;
        REG_RD = !wr;
        REG_WDATA = d;
        n = 0;
        ack = 1'h0;
        q = REG_RDATA;
        while (!ack && n < 8) begin
            // Sampled once settled, before the rising edge that takes the request
            #1;
            ack = (SLAVE_SYNC === 1'h1);
            q = REG_RDATA;
            @(negedge MCLK);
            n++;
        end
    endtask

    // Released data is inverted so a stale word never looks valid
    // One idle edge follows, so the next request never reassigns in the same step
    task automatic idle();
        REG_WR = 1'h0;
        REG_RD = 1'h0;
        REG_WDATA = ~REG_WDATA;
        @(negedge MCLK);
    endtask
endmodule // host_model

// >>> loop_select.sv
// Maintenance loop steering of receiver input and bit clocks
`timescale 1ns/10ps
module loop_select (
    // Mode and maintenance bits
    input wire logic [1:0] mode,
    input wire logic inject,
    input wire logic step,
    // Normal-path signals
    input wire logic line_in,
    input wire logic tx_clk_en,
    input wire logic rx_clk_en,
    // Steered results
    output logic rx_data,
    output logic tx_bit_clk,
    output logic rx_bit_clk,
    output logic in_loop
);
    // Both loop modes substitute the register bits for the line and clocks
    always_comb begin
        in_loop = (mode == tx_status_pkg::MODE_INT_LOOP) ||
                  (mode == tx_status_pkg::MODE_EXT_LOOP);
        rx_data = in_loop ? inject : line_in;
        tx_bit_clk = in_loop ? step : tx_clk_en;
        rx_bit_clk = in_loop ? step : rx_clk_en;
    end
endmodule // loop_select

// >>> tx_status_maint_control.sv
// Transmitter status and maintenance control register bank
`timescale 1ns/10ps
module tx_status_maint_control (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Host register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic SLAVE_SYNC,
    // Transmitter side
    input wire logic LOAD_TRANSMIT_BUFFER_STROBE,
    input wire logic FIRST_BIT_SENT,
    input wire logic TX_CLK_EN,
    input wire logic RX_CLK_EN,
    // Receiver line pin
    input wire logic LINE_IN,
    // Outputs toward datapaths
    output logic RX_SERIAL_IN,
    output logic TX_BIT_CLK,
    output logic RX_BIT_CLK,
    output logic CLEAR_PULSE,
    output logic TX_INT_REQ,
    output logic [1:0] OPERATING_SELECTOR
);
    // Register state
    logic loop_inject_bit;
    logic step_clock_bit;
    logic [1:0] sel;
    logic done;
    logic ie;
    logic clr;
    logic req;

    // Next values
    logic next_loop_inject_bit;
    logic next_step_clock_bit;
    logic [1:0] next_sel;
    logic next_done;
    logic next_ie;
    logic next_clr;
    logic next_req;

    // Pin synchroniser state
    logic [2:0] line_sync;
    logic line_q;
    logic [2:0] next_line_sync;
    logic next_line_q;

    // Steered receiver path
    logic rx_data;
    logic in_loop;

    // Three-stage pin synchroniser; change accepted when stages two and three agree
    always_comb begin
        next_line_sync = {line_sync[1:0], LINE_IN};
        next_line_q = (line_sync[1] == line_sync[2]) ? line_sync[2] : line_q;
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            line_sync <= 3'h0;
            line_q <= 1'h0;
        end else begin
            line_sync <= next_line_sync;
            line_q <= next_line_q;
        end
    end

    loop_select u_loop (
        .mode(sel),
        .inject(loop_inject_bit),
        .step(step_clock_bit),
        .line_in(line_q),
        .tx_clk_en(TX_CLK_EN),
        .rx_clk_en(RX_CLK_EN),
        .rx_data(rx_data),
        .tx_bit_clk(TX_BIT_CLK),
        .rx_bit_clk(RX_BIT_CLK),
        .in_loop(in_loop)
    );

    // Register next state; the clear pulse acts like initialization one cycle later
    always_comb begin
        logic wr_ok;
        wr_ok = REG_WR && !clr; // Writes during the clear are held off by sync
        next_loop_inject_bit = loop_inject_bit;
        next_step_clock_bit = step_clock_bit;
        next_sel = sel;
        next_ie = ie;
        next_done = done;
        next_clr = wr_ok && REG_WDATA[tx_status_pkg::MASTER_CLEAR_POS];
        next_req = req;
        // Read-only bits 10 and 07 are never taken from the write data
        if (wr_ok) begin
            next_loop_inject_bit = REG_WDATA[tx_status_pkg::LOOP_INJECT_POS];
            next_step_clock_bit = REG_WDATA[tx_status_pkg::STEP_CLOCK_POS];
            next_sel = REG_WDATA[tx_status_pkg::SEL_HI_POS:tx_status_pkg::SEL_LO_POS];
            next_ie = REG_WDATA[tx_status_pkg::SENT_IE_POS];
        end
        // Done set by first bit out wins over a same-cycle load clear
        if (LOAD_TRANSMIT_BUFFER_STROBE) begin
            next_done = 1'h0;
        end
        if (FIRST_BIT_SENT) begin
            next_done = 1'h1;
        end
        // Request latches on the rising edge of done while enabled
        if (next_done && !done && next_ie) begin
            next_req = 1'h1;
        end
        if (!next_done || !next_ie) begin
            next_req = 1'h0;
        end
        // Clear overrides everything, so a write in the same word cannot survive it
        if (clr) begin
            next_loop_inject_bit = 1'h0;
            next_step_clock_bit = 1'h0;
            next_sel = tx_status_pkg::MODE_NORMAL;
            next_ie = 1'h0;
            next_done = 1'h1;
            next_req = 1'h0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            loop_inject_bit <= 1'h0;
            step_clock_bit <= 1'h0;
            sel <= 2'h0;
            ie <= 1'h0;
            done <= 1'h1;
            clr <= 1'h0;
            req <= 1'h0;
        end else begin
            loop_inject_bit <= next_loop_inject_bit;
            step_clock_bit <= next_step_clock_bit;
            sel <= next_sel;
            ie <= next_ie;
            done <= next_done;
            clr <= next_clr;
            req <= next_req;
        end
    end

    // Read mux; master clear and unused bits read zero
    always_comb begin
        REG_RDATA = tx_status_pkg::READ_ZERO;
        REG_RDATA[tx_status_pkg::LOOP_INJECT_POS] = loop_inject_bit;
        REG_RDATA[tx_status_pkg::STEP_CLOCK_POS] = step_clock_bit;
        REG_RDATA[tx_status_pkg::SEL_HI_POS:tx_status_pkg::SEL_LO_POS] = sel;
        REG_RDATA[tx_status_pkg::MONITOR_POS] = in_loop & rx_data;
        REG_RDATA[tx_status_pkg::DONE_POS] = done;
        REG_RDATA[tx_status_pkg::SENT_IE_POS] = ie;
    end

    // Acknowledge any access except while clearing
    assign SLAVE_SYNC = (REG_WR || REG_RD) && !clr;
    assign CLEAR_PULSE = clr;
    assign TX_INT_REQ = req;
    assign RX_SERIAL_IN = rx_data;
    assign OPERATING_SELECTOR = sel;

    // Master clear pulse, acknowledge and initialization
    a_clear_one_cycle: assert property (@(posedge MCLK) disable iff (!NRST)
        clr |=> !clr)
        else $error("clear pulse longer than one cycle");
    a_clear_from_write: assert property (@(posedge MCLK) disable iff (!NRST)
        (REG_WR && !clr && REG_WDATA[tx_status_pkg::MASTER_CLEAR_POS]) |=> clr)
        else $error("clear not produced");
    a_sync_held_off: assert property (@(posedge MCLK) disable iff (!NRST)
        clr |-> !SLAVE_SYNC)
        else $error("sync during clear");
    a_sync_answer: assert property (@(posedge MCLK) disable iff (!NRST)
        ((REG_WR || REG_RD) && !clr) |-> SLAVE_SYNC)
        else $error("access not acknowledged");
    a_clear_restores: assert property (@(posedge MCLK) disable iff (!NRST)
        clr |=> (done && !ie && !loop_inject_bit && !step_clock_bit &&
            sel == tx_status_pkg::MODE_NORMAL))
        else $error("clear did not restore");
    a_reset_state: assert property (@(posedge MCLK)
        !NRST |=> (done && !ie && !req && !clr && !loop_inject_bit && !step_clock_bit &&
            sel == tx_status_pkg::MODE_NORMAL))
        else $error("initialization did not restore");
    // Loop steering and the receiver input monitor
    a_loop_data_path: assert property (@(posedge MCLK) disable iff (!NRST)
        in_loop |-> (RX_SERIAL_IN == loop_inject_bit))
        else $error("loop data wrong");
    a_loop_step_clock: assert property (@(posedge MCLK) disable iff (!NRST)
        in_loop |-> (TX_BIT_CLK == step_clock_bit && RX_BIT_CLK == step_clock_bit))
        else $error("step clock not used");
    a_monitor_read: assert property (@(posedge MCLK) disable iff (!NRST)
        !in_loop |-> !REG_RDATA[tx_status_pkg::MONITOR_POS])
        else $error("monitor outside loop");
    a_monitor_loop: assert property (@(posedge MCLK) disable iff (!NRST)
        in_loop |-> (REG_RDATA[tx_status_pkg::MONITOR_POS] == RX_SERIAL_IN))
        else $error("monitor does not follow receiver input");
    // Host writes to the read/write bits land one cycle later; clear acts a cycle after that
    a_inject_write: assert property (@(posedge MCLK) disable iff (!NRST)
        (REG_WR && !clr) |=>
            (loop_inject_bit == $past(REG_WDATA[tx_status_pkg::LOOP_INJECT_POS])))
        else $error("inject bit not written");
    a_step_write: assert property (@(posedge MCLK) disable iff (!NRST)
        (REG_WR && !clr) |=>
            (step_clock_bit == $past(REG_WDATA[tx_status_pkg::STEP_CLOCK_POS])))
        else $error("step bit not written");
    a_sel_write: assert property (@(posedge MCLK) disable iff (!NRST)
        (REG_WR && !clr) |=>
            (OPERATING_SELECTOR ==
                $past(REG_WDATA[tx_status_pkg::SEL_HI_POS:tx_status_pkg::SEL_LO_POS])))
        else $error("selector not written");
    a_ie_write: assert property (@(posedge MCLK) disable iff (!NRST)
        (REG_WR && !clr) |=>
            (ie == $past(REG_WDATA[tx_status_pkg::SENT_IE_POS])))
        else $error("interrupt enable not written");
    // Done flag, its interrupt request and the master clear read-back
    a_done_set_first: assert property (@(posedge MCLK) disable iff (!NRST)
        FIRST_BIT_SENT |=> done)
        else $error("done not set");
    a_done_load_clear: assert property (@(posedge MCLK) disable iff (!NRST)
        (LOAD_TRANSMIT_BUFFER_STROBE && !FIRST_BIT_SENT && !clr) |=> !done)
        else $error("done not cleared");
    a_done_read_only: assert property (@(posedge MCLK) disable iff (!NRST)
        (REG_WR && !done && !FIRST_BIT_SENT && !clr) |=> !done)
        else $error("done set by a write");
    a_req_gated: assert property (@(posedge MCLK) disable iff (!NRST)
        TX_INT_REQ |-> (done && ie))
        else $error("request without enable");
    a_req_on_done: assert property (@(posedge MCLK) disable iff (!NRST)
        ($rose(done) && ie) |-> TX_INT_REQ)
        else $error("no request when done set");
    a_clear_reads_zero: assert property (@(posedge MCLK) disable iff (!NRST)
        !REG_RDATA[tx_status_pkg::MASTER_CLEAR_POS])
        else $error("master clear bit reads one");
    // Main scenarios
    c_master_clear: cover property (@(posedge MCLK) disable iff (!NRST) clr);
    c_int_req: cover property (@(posedge MCLK) disable iff (!NRST) $rose(TX_INT_REQ));
    c_loop_mode: cover property (@(posedge MCLK) disable iff (!NRST) in_loop && step_clock_bit);
    c_clear_refused: cover property (@(posedge MCLK) disable iff (!NRST) clr && REG_RD);
    c_done_race: cover property (@(posedge MCLK) disable iff (!NRST)
        LOAD_TRANSMIT_BUFFER_STROBE && FIRST_BIT_SENT);
endmodule // tx_status_maint_control

// >>> tx_status_maint_control_tb.sv
// Self-checking bench for the transmitter status register bank
`timescale 1ns/10ps
module tx_status_maint_control_tb;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic ld = 1'h0;
    logic first = 1'h0;
    logic line_in = 1'h0;
    logic clk_en = 1'h0;
    logic wr_req, rd_req, sync, rx_in, tx_clk, rx_clk, clr, irq;
    logic [15:0] wdata, rdata, q;
    logic [1:0] sel;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    always #2.5 mclk = ~mclk;

    tx_status_maint_control dut (.MCLK(mclk), .NRST(nrst), .REG_WR(wr_req), .REG_RD(rd_req),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .SLAVE_SYNC(sync),
        .LOAD_TRANSMIT_BUFFER_STROBE(ld), .FIRST_BIT_SENT(first), .TX_CLK_EN(clk_en),
        .RX_CLK_EN(clk_en), .LINE_IN(line_in), .RX_SERIAL_IN(rx_in), .TX_BIT_CLK(tx_clk),
        .RX_BIT_CLK(rx_clk), .CLEAR_PULSE(clr), .TX_INT_REQ(irq), .OPERATING_SELECTOR(sel));
    host_model host (.MCLK(mclk), .SLAVE_SYNC(sync), .REG_RDATA(rdata), .REG_WR(wr_req),
        .REG_RD(rd_req), .REG_WDATA(wdata));

    // Ceiling far above the roughly 140 cycles the scenarios take
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Single bus cycles, each acknowledged at once and followed by one idle edge
    task automatic wr(input logic [15:0] d);
        host.xfer(1'h1, d, q, n);
        host.idle();
        chk(n, 16'h0001);
    endtask

    task automatic rd();
        host.xfer(1'h0, 16'h0000, q, n);
        host.idle();
        chk(n, 16'h0001);
    endtask

    // One-cycle pulse of the load strobe or of the first-bit event, then one quiet edge
    task automatic strobe(input logic is_load);
        ld = is_load;
        first = !is_load;
        @(negedge mclk);
        ld = 1'h0;
        first = 1'h0;
        @(negedge mclk);
    endtask

    task automatic t_reset();
        rd();
        chk(q, 16'h0080);
        chk(irq, 1'h0);
        chk(sel, 2'h0);
        chk(clr, 1'h0);
    endtask

    // Every mode with maintenance bits opposite to the normal-path inputs
    task automatic t_modes();
        logic v, lp;
        for (int i = 0; i < 8; i++) begin
            v = i[2];
            lp = (i[1:0] == 2'h1) || (i[1:0] == 2'h2);
            line_in = !v;
            clk_en = !v;
            repeat (6) @(negedge mclk);
            wr({1'h0, v, v, i[1:0], 11'h480});
            rd();
            chk(q, {1'h0, v, v, i[1:0], lp & v, 10'h080});
            chk(sel, i[1:0]);
            chk(rx_in, lp ? v : !v);
            chk(tx_clk, lp ? v : !v);
            chk(rx_clk, lp ? v : !v);
        end
    endtask

    // Master clear with every writable bit set, then at once a read that must stall
    task automatic t_clear();
        host.xfer(1'h1, 16'h7940, q, n);
        chk(clr, 1'h1);
        host.xfer(1'h0, 16'h0000, q, n);
        host.idle();
        chk(n, 16'h0002);
        chk(q, 16'h0080);
        chk(clr, 1'h0);
    endtask

    task automatic t_done();
        wr(16'h0040);
        strobe(1'h1);
        wr(16'h00C0);
        rd();
        chk(q, 16'h0040);
        chk(irq, 1'h0);
        strobe(1'h0);
        chk(irq, 1'h1);
        rd();
        chk(q, 16'h00C0);
        wr(16'h0000);
        rd();
        chk(irq, 1'h0);
        strobe(1'h1);
        strobe(1'h0);
        chk(irq, 1'h0);
        // Load and first bit in one cycle: the set must win
        strobe(1'h1);
        ld = 1'h1;
        first = 1'h1;
        @(negedge mclk);
        ld = 1'h0;
        first = 1'h0;
        rd();
        chk(q, 16'h0080);
    endtask

    // Mid-run initialization with every read/write bit set and done cleared
    task automatic t_init();
        wr(16'h7840);
        strobe(1'h1);
        nrst = 1'h0;
        repeat (3) @(negedge mclk);
        nrst = 1'h1;
        rd();
        chk(q, 16'h0080);
        chk(sel, 2'h0);
        chk(irq, 1'h0);
    endtask

    // Reset held 20 cycles, then the scenarios
    initial begin
        repeat (20) @(negedge mclk);
        nrst = 1'h1;
        t_reset();
        t_modes();
        t_clear();
        t_done();
        t_init();
        conclude();
    end
endmodule // tx_status_maint_control_tb

// >>> tx_status_pkg.sv
// Constants for the transmitter status and maintenance control register
// Overview of operation
// - In either loop mode, bit 14 drives the receiver serial input.
// - Bit 14 is read/write, cleared by initialization and master clear.
// - In either loop mode, bit 13 replaces the transmitter and receiver bit clocks.
// - Bit 13 is read/write, cleared by initialization or master clear.
// - Bits 12:11 select normal, internal loop, external loop or system test.
// - Selector bits are read/write and return to normal on any reset.
// - Bit 10 reads the receiver serial input in loop modes; writes ignored.
// - Writing one to bit 08 produces a clear pulse for the whole interface.
// - Slave-sync acknowledge is withheld while the clear pulse is active.
// - Initialization and master clear both set the done flag.
// - Done flag is read-only and cleared by the buffer load strobe.
// - Bit 06 gates done interrupts, is read/write, cleared by any reset.
package tx_status_pkg;
    localparam int REG_W = 16;
    localparam int LOOP_INJECT_POS = 14;
    localparam int STEP_CLOCK_POS = 13;
    localparam int SEL_HI_POS = 12;
    localparam int SEL_LO_POS = 11;
    localparam int MONITOR_POS = 10;
    localparam int MASTER_CLEAR_POS = 8;
    localparam int DONE_POS = 7;
    localparam int SENT_IE_POS = 6;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_INT_LOOP = 2'h1,
        MODE_EXT_LOOP = 2'h2,
        MODE_SYS_TEST = 2'h3
    } op_mode_t;
    localparam logic [15:0] READ_ZERO = 16'h0000;
endpackage
